// ===== design/lcis_chan.sv
// One channel: sticky event flags, loop code edge detect and the 16-bit error counter
`timescale 1ns/10ps
`include "lcis_map.svh"
module lcis_chan (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    lcis_chan_if.chan cif // Events in, flags out
);
    localparam int CW = `LCIS_ERROR_COUNT_VALUE_W;

    // All checks below run on the system clock and sleep through reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    lcis_pkg::lcis_line_t line_ff, nxt_line;
    lcis_pkg::lcis_loop_t loop_ff, nxt_loop;
    logic edge_ff, nxt_edge;
    logic prev_ff, nxt_prev;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic ovf;
    logic act_ev;

    // Next flag values; an event in the clearing cycle wins over the clear
    always_comb begin
        ovf = cif.ev_error_count_value && (cnt_ff == {CW{1'b1}});
        nxt_cnt = cif.ev_error_count_value ? cnt_ff + {{(CW-1){1'b0}}, 1'b1} : cnt_ff;
        nxt_line = line_ff & ~cif.clr_line;
        nxt_line[`LCIS_BIT_SYS_BIPOLAR_VIOLATION] = nxt_line[`LCIS_BIT_SYS_BIPOLAR_VIOLATION] | cif.ev_sys_bipolar_violation;
        nxt_line[`LCIS_BIT_LINE_BIPOLAR_VIOLATION] = nxt_line[`LCIS_BIT_LINE_BIPOLAR_VIOLATION] | cif.ev_line_bipolar_violation;
        nxt_line[`LCIS_BIT_SYS_EXCESS_ZEROS] = nxt_line[`LCIS_BIT_SYS_EXCESS_ZEROS] | cif.ev_sys_excess_zeros;
        nxt_line[`LCIS_BIT_LINE_EXCESS_ZEROS] = nxt_line[`LCIS_BIT_LINE_EXCESS_ZEROS] | cif.ev_line_excess_zeros;
        nxt_line[`LCIS_BIT_PERR] = nxt_line[`LCIS_BIT_PERR] | cif.ev_perr;
        nxt_line[`LCIS_BIT_CNTOV] = nxt_line[`LCIS_BIT_CNTOV] | ovf;
        // Edge select 0 catches only the rise, 1 catches either change
        act_ev = edge_ff ? (cif.act_state ^ prev_ff) : (cif.act_state & ~prev_ff);
        nxt_loop = loop_ff & ~cif.clr_loop;
        nxt_loop[`LCIS_BIT_ACT] = nxt_loop[`LCIS_BIT_ACT] | act_ev;
        nxt_loop[`LCIS_BIT_DEACT] = nxt_loop[`LCIS_BIT_DEACT] | cif.ev_deact;
        nxt_edge = cif.edge_we ? cif.edge_wdata : edge_ff;
        nxt_prev = cif.act_state;
    end

    // Registers; the state history resets low so a state high at release counts as a rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_ff <= `LCIS_LINE_RST;
            loop_ff <= `LCIS_LOOP_RST;
            edge_ff <= 1'b0;
            prev_ff <= 1'b0;
            cnt_ff <= `LCIS_ERROR_COUNT_VALUE_RST;
        end else begin
            line_ff <= nxt_line;
            loop_ff <= nxt_loop;
            edge_ff <= nxt_edge;
            prev_ff <= nxt_prev;
            cnt_ff <= nxt_cnt;
        end
    end

    // Outputs straight from flops
    assign cif.line_flags = line_ff;
    assign cif.loop_flags = loop_ff;
    assign cif.edge_sel = edge_ff;
    assign cif.err_count = cnt_ff;

    property p_sys_bipolar_violation_set;
        cif.ev_sys_bipolar_violation |=> line_ff[5] && cif.line_flags[5];
    endproperty
    a_sys_bipolar_violation_set: assert property (p_sys_bipolar_violation_set) else $error("sys bipolar flag not set");

    property p_line_bipolar_violation_set;
        cif.ev_line_bipolar_violation |=> line_ff[4];
    endproperty
    a_line_bipolar_violation_set: assert property (p_line_bipolar_violation_set) else $error("line bipolar flag not set");

    property p_exz_set;
        (cif.ev_sys_excess_zeros || cif.ev_line_excess_zeros)
            |=> ((line_ff[3:2] & $past({cif.ev_sys_excess_zeros, cif.ev_line_excess_zeros})) == $past({cif.ev_sys_excess_zeros, cif.ev_line_excess_zeros}));
    endproperty
    a_exz_set: assert property (p_exz_set) else $error("excess zero flags not set");

    property p_perr_set;
        cif.ev_perr |=> line_ff[1];
    endproperty
    a_perr_set: assert property (p_perr_set) else $error("pattern error flag not set");

    property p_ovf_set;
        (cif.ev_error_count_value && cnt_ff == 16'hFFFF) |=> line_ff[0] && cnt_ff == 16'h0000;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("counter overflow not flagged");

    property p_flag_hold;
        (line_ff[5] && !cif.clr_line[5]) |=> line_ff[5] [*2] or (line_ff[5] ##1 $past(cif.clr_line[5]));
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clear");

    property p_flag_clear;
        (cif.clr_line[3] && !cif.ev_sys_excess_zeros) |=> !line_ff[3];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("written one did not clear flag");

    property p_act_rise;
        (!edge_ff && !prev_ff && cif.act_state) |=> loop_ff[1];
    endproperty
    a_act_rise: assert property (p_act_rise) else $error("activate rise not flagged");

    property p_act_fall;
        (prev_ff && !cif.act_state && !loop_ff[1] && !cif.edge_we) |=> (loop_ff[1] == $past(edge_ff));
    endproperty
    a_act_fall: assert property (p_act_fall) else $error("activate fall handled wrongly");

    property p_deact_set;
        cif.ev_deact |=> loop_ff[0];
    endproperty
    a_deact_set: assert property (p_deact_set) else $error("deactivate flag not set");

    property p_cnt_inc;
        cif.ev_error_count_value |=> cnt_ff == $past(cnt_ff) + 16'h0001;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("error counter did not advance");
endmodule // lcis_chan

// ===== design/lcis_chan_if.sv
// Signals between the register front end and one channel's flag logic
`timescale 1ns/10ps
`include "lcis_map.svh"
interface lcis_chan_if;
    logic ev_sys_bipolar_violation;
    logic ev_line_bipolar_violation;
    logic ev_sys_excess_zeros;
    logic ev_line_excess_zeros;
    logic ev_perr;
    logic ev_error_count_value;
    logic act_state;
    logic ev_deact;
    lcis_pkg::lcis_line_t clr_line;
    lcis_pkg::lcis_loop_t clr_loop;
    logic edge_we;
    logic edge_wdata;
    lcis_pkg::lcis_line_t line_flags;
    lcis_pkg::lcis_loop_t loop_flags;
    logic edge_sel;
    logic [`LCIS_ERROR_COUNT_VALUE_W-1:0] err_count;

    modport front (
        output ev_sys_bipolar_violation, ev_line_bipolar_violation, ev_sys_excess_zeros, ev_line_excess_zeros, ev_perr, ev_error_count_value, act_state, ev_deact,
        output clr_line, clr_loop, edge_we, edge_wdata,
        input line_flags, loop_flags, edge_sel, err_count
    );
    modport chan (
        input ev_sys_bipolar_violation, ev_line_bipolar_violation, ev_sys_excess_zeros, ev_line_excess_zeros, ev_perr, ev_error_count_value, act_state, ev_deact,
        input clr_line, clr_loop, edge_we, edge_wdata,
        output line_flags, loop_flags, edge_sel, err_count
    );
endinterface

// ===== design/lcis_map.svh
// Register indices, field positions, reset values and bus constants for the channel interrupt status block
`ifndef LCIS_MAP_SVH
`define LCIS_MAP_SVH

// Register index = channel group base + offset; byte address = index * 4
`define LCIS_AXI_AW 13
`define LCIS_CH0_GRP 5'h1F
`define LCIS_OFF_STATE 6'h1F
`define LCIS_OFF_EDGE 6'h20
`define LCIS_OFF_LOOP 6'h21
`define LCIS_OFF_LINE 6'h22
`define LCIS_OFF_ERRL 6'h23
`define LCIS_OFF_ERRH 6'h24

// Field positions in line_event_interrupt_flags
`define LCIS_BIT_SYS_BIPOLAR_VIOLATION 5
`define LCIS_BIT_LINE_BIPOLAR_VIOLATION 4
`define LCIS_BIT_SYS_EXCESS_ZEROS 3
`define LCIS_BIT_LINE_EXCESS_ZEROS 2
`define LCIS_BIT_PERR 1
`define LCIS_BIT_CNTOV 0

// Field positions in the loop code flag, state and edge select registers
`define LCIS_BIT_ACT 1
`define LCIS_BIT_DEACT 0
`define LCIS_BIT_EDGE 0

// Reset values and widths
`define LCIS_LINE_RST 6'h00
`define LCIS_LOOP_RST 2'h0
`define LCIS_ERROR_COUNT_VALUE_W 16
`define LCIS_ERROR_COUNT_VALUE_RST 16'h0000

// AXI responses
`define LCIS_RESP_OKAY 2'h0
`define LCIS_RESP_SLVERR 2'h2

`endif

// ===== design/lcis_pkg.sv
// Types shared by the channel interrupt status block
package lcis_pkg;
    typedef enum logic [2:0] {
        LCIS_SEL_NONE,
        LCIS_SEL_STATE,
        LCIS_SEL_EDGE,
        LCIS_SEL_LOOP,
        LCIS_SEL_LINE,
        LCIS_SEL_ERRL,
        LCIS_SEL_ERRH
    } lcis_sel_t;

    typedef struct packed {
        logic hit;
        logic [3:0] ch;
        lcis_sel_t sel;
    } lcis_dec_t;

    typedef logic [5:0] lcis_line_t;
    typedef logic [1:0] lcis_loop_t;
endpackage

// ===== design/lcis_top.sv
// Per-channel line event interrupt flags behind an AXI4-Lite slave, with the shared interrupt pin
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "lcis_map.svh"
module lcis_top #(
    parameter int NCH = 9 // Channels, channel 0 being the extra one
) (
    input wire logic aclk, // System clock, 100 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [`LCIS_AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [`LCIS_AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [NCH-1:0] sys_bipolar_violation, // Pulse per event
    input wire logic [NCH-1:0] line_bipolar_violation, // Pulse per event
    input wire logic [NCH-1:0] sys_excess_zeros, // Pulse per event
    input wire logic [NCH-1:0] line_excess_zeros, // Pulse per event
    input wire logic [NCH-1:0] pattern_error, // Pulse per checker error
    input wire logic [NCH-1:0] error_count_event, // Pulse per counted error
    input wire logic [NCH-1:0] loop_activate_code_state, // Level
    input wire logic [NCH-1:0] loop_deactivate_code, // Pulse per detection
    output logic int_n // Interrupt, active low
);
    if (NCH < 2 || NCH > 16) begin : g_bad_nch
        $error("lcis_top: NCH must lie in 2..16");
    end

    lcis_chan_if cif [NCH] ();

    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [`LCIS_AXI_AW-1:0] awaddr_ff, nxt_awaddr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic wlane_ff, nxt_wlane;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic int_n_ff, nxt_int_n;
    logic commit;
    lcis_pkg::lcis_dec_t wdec, rdec;
    logic [31:0] rd_word;
    lcis_pkg::lcis_line_t line_a [NCH];
    lcis_pkg::lcis_loop_t loop_a [NCH];
    logic [NCH-1:0] edge_a, state_a, any_a;
    logic [`LCIS_ERROR_COUNT_VALUE_W-1:0] error_count_value_a [NCH];

    // Byte address to channel and register; the top five index bits pick the channel group
    function automatic lcis_pkg::lcis_dec_t dec_f(input logic [`LCIS_AXI_AW-1:0] a);
        lcis_pkg::lcis_dec_t d;
        logic [4:0] grp;
        logic chan_ok;
        grp = a[12:8];
        d.ch = (grp == `LCIS_CH0_GRP) ? 4'h0 : grp[3:0] + 4'h1;
        chan_ok = (grp == `LCIS_CH0_GRP) || (grp < 5'(NCH - 1));
        case (a[7:2])
            `LCIS_OFF_STATE: d.sel = lcis_pkg::LCIS_SEL_STATE;
            `LCIS_OFF_EDGE: d.sel = lcis_pkg::LCIS_SEL_EDGE;
            `LCIS_OFF_LOOP: d.sel = lcis_pkg::LCIS_SEL_LOOP;
            `LCIS_OFF_LINE: d.sel = lcis_pkg::LCIS_SEL_LINE;
            `LCIS_OFF_ERRL: d.sel = lcis_pkg::LCIS_SEL_ERRL;
            `LCIS_OFF_ERRH: d.sel = lcis_pkg::LCIS_SEL_ERRH;
            default: d.sel = lcis_pkg::LCIS_SEL_NONE;
        endcase
        d.hit = chan_ok && (a[1:0] == 2'h0) && (d.sel != lcis_pkg::LCIS_SEL_NONE);
        return d;
    endfunction

    assign wdec = dec_f(awaddr_ff);
    assign rdec = dec_f(s_axi_araddr);
    assign commit = aw_got_ff && w_got_ff && !bvalid_ff;

    // Channel instances, their events and their write strobes
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic sel_me;
        assign sel_me = commit && wdec.hit && wlane_ff && (wdec.ch == 4'(i));
        assign cif[i].ev_sys_bipolar_violation = sys_bipolar_violation[i];
        assign cif[i].ev_line_bipolar_violation = line_bipolar_violation[i];
        assign cif[i].ev_sys_excess_zeros = sys_excess_zeros[i];
        assign cif[i].ev_line_excess_zeros = line_excess_zeros[i];
        assign cif[i].ev_perr = pattern_error[i];
        assign cif[i].ev_error_count_value = error_count_event[i];
        assign cif[i].act_state = loop_activate_code_state[i];
        assign cif[i].ev_deact = loop_deactivate_code[i];
        // Written ones clear; a zero byte leaves every flag alone
        assign cif[i].clr_line = (sel_me && wdec.sel == lcis_pkg::LCIS_SEL_LINE) ? wdata_ff[5:0] : 6'h00;
        assign cif[i].clr_loop = (sel_me && wdec.sel == lcis_pkg::LCIS_SEL_LOOP) ? wdata_ff[1:0] : 2'h0;
        assign cif[i].edge_we = sel_me && (wdec.sel == lcis_pkg::LCIS_SEL_EDGE);
        assign cif[i].edge_wdata = wdata_ff[`LCIS_BIT_EDGE];
        assign line_a[i] = cif[i].line_flags;
        assign loop_a[i] = cif[i].loop_flags;
        assign edge_a[i] = cif[i].edge_sel;
        assign error_count_value_a[i] = cif[i].err_count;
        assign state_a[i] = loop_activate_code_state[i];
        assign any_a[i] = (|line_a[i]) || (|loop_a[i]);
        lcis_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .cif(cif[i])
        );
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (rdec.hit) begin
            case (rdec.sel)
                lcis_pkg::LCIS_SEL_STATE: rd_word[`LCIS_BIT_ACT] = state_a[rdec.ch];
                lcis_pkg::LCIS_SEL_EDGE: rd_word[`LCIS_BIT_EDGE] = edge_a[rdec.ch];
                lcis_pkg::LCIS_SEL_LOOP: rd_word[1:0] = loop_a[rdec.ch];
                lcis_pkg::LCIS_SEL_LINE: rd_word[5:0] = line_a[rdec.ch];
                lcis_pkg::LCIS_SEL_ERRL: rd_word[7:0] = error_count_value_a[rdec.ch][7:0];
                lcis_pkg::LCIS_SEL_ERRH: rd_word[7:0] = error_count_value_a[rdec.ch][15:8];
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    // Bus handshakes: address and data may come in either order, one write and one read at a time
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;

    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_got = w_got_ff;
        nxt_wdata = wdata_ff;
        nxt_wlane = wlane_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata[7:0];
            nxt_wlane = s_axi_wstrb[0];
        end
        if (commit) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wdec.hit ? `LCIS_RESP_OKAY : `LCIS_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_word;
            nxt_rresp = rdec.hit ? `LCIS_RESP_OKAY : `LCIS_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        // Pin follows flags one cycle later so it never glitches
        nxt_int_n = !(|any_a);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= '0;
            w_got_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `LCIS_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `LCIS_RESP_OKAY;
            int_n_ff <= 1'b1;
        end else begin
            aw_got_ff <= nxt_aw_got;
            awaddr_ff <= nxt_awaddr;
            w_got_ff <= nxt_w_got;
            wdata_ff <= nxt_wdata;
            wlane_ff <= nxt_wlane;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            int_n_ff <= nxt_int_n;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign int_n = int_n_ff;

    property p_int_low;
        @(posedge aclk) disable iff (!aresetn) (|any_a) |=> !int_n;
    endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt pin not low with a flag set");

    property p_int_high;
        @(posedge aclk) disable iff (!aresetn) !(|any_a) |=> int_n;
    endproperty
    a_int_high: assert property (p_int_high) else $error("interrupt pin low with no flag set");

    property p_ch0_line_read;
        @(posedge aclk) disable iff (!aresetn)
            (s_axi_arvalid && s_axi_arready && s_axi_araddr == 13'h1F88)
            |=> s_axi_rvalid && s_axi_rdata[5:0] == $past(line_a[0]) && s_axi_rresp == 2'h0;
    endproperty
    a_ch0_line_read: assert property (p_ch0_line_read) else $error("channel 0 flag read wrong");
endmodule // lcis_top

// ===== tb/lcis_tb.sv
// Self-checking bench for the channel interrupt status block over AXI4-Lite
`timescale 1ns/10ps
`include "lcis_map.svh"
module testbench;
    localparam int NCH = 9;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [`LCIS_AXI_AW-1:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [`LCIS_AXI_AW-1:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [NCH-1:0] ev [6] = '{default: '0}; // Index equals the flag bit the event sets; index 0 counts errors and sets bit 0 only on overflow
    logic [NCH-1:0] loop_activate_code_state = '0;
    logic [NCH-1:0] loop_deactivate_code = '0;
    logic int_n;
    int miscompares = 0;
    int check_count = 0;

    lcis_top #(.NCH(NCH)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sys_bipolar_violation(ev[5]), .line_bipolar_violation(ev[4]), .sys_excess_zeros(ev[3]),
        .line_excess_zeros(ev[2]), .pattern_error(ev[1]), .error_count_event(ev[0]),
        .loop_activate_code_state, .loop_deactivate_code, .int_n
    );

    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic stop_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic hang(input string name);
        miscompares++;
        $display("[ERR] %s expected handshake seen timeout", name);
        stop_test();
    endtask

    // Byte address of a register: channel 0 lives in the top group, channel n in group n-1
    function automatic logic [12:0] ra(input int ch, input logic [5:0] off);
        logic [4:0] grp;
        grp = (ch == 0) ? `LCIS_CH0_GRP : 5'(ch - 1);
        return {grp, off, 2'b00};
    endfunction

    // Ready is sampled at the falling edge, where it is settled, and acted on at the next rising edge
    task automatic axi_write(input logic [12:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic pa, pw, pb, aw_ok, w_ok, b_ok;
        logic [1:0] r;
        int n;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        n = 0;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pb) begin
            @(negedge aclk);
            aw_ok = s_axi_awready;
            w_ok = s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (pa && aw_ok === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && w_ok === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (b_ok === 1'b1) begin
                s_axi_bready <= 1'b0;
                resp = r;
                pb = 1'b0;
            end
            n++;
            if (n > 50) hang("write");
        end
    endtask

    task automatic axi_read(input logic [12:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic pa, pr, ar_ok, r_ok;
        int n;
        pa = 1'b1;
        pr = 1'b1;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (pr) begin
            @(negedge aclk);
            ar_ok = s_axi_arready;
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (pa && ar_ok === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (!pa && r_ok === 1'b1) begin
                s_axi_rready <= 1'b0;
                pr = 1'b0;
            end
            n++;
            if (n > 50) hang("read");
        end
    endtask

    task automatic rd_chk(input string name, input logic [12:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(name, exp, d);
        check({name, " resp"}, {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd_ok(input string name, input logic [12:0] a, input logic [31:0] exp);
        rd_chk(name, a, exp, `LCIS_RESP_OKAY);
    endtask

    task automatic wr_chk(input logic [12:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, r);
        check("write resp", {30'h0, er}, {30'h0, r});
    endtask

    // Kind 6 is the deactivate code, the rest index the event vectors
    task automatic pulse(input int k, input int ch);
        @(posedge aclk);
        if (k == 6) loop_deactivate_code[ch] <= 1'b1;
        else ev[k][ch] <= 1'b1;
        @(posedge aclk);
        if (k == 6) loop_deactivate_code[ch] <= 1'b0;
        else ev[k][ch] <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic act(input logic v);
        @(posedge aclk);
        loop_activate_code_state[1] <= v;
        repeat (3) @(posedge aclk);
    endtask

    task automatic pin_chk(input string name, input logic exp);
        @(negedge aclk);
        check(name, {31'h0, exp}, {31'h0, int_n});
    endtask

    task automatic t_reset();
        rd_ok("line flags", ra(1, `LCIS_OFF_LINE), 32'h0);
        rd_ok("loop flags", ra(1, `LCIS_OFF_LOOP), 32'h0);
        pin_chk("int_n idle", 1'b1);
    endtask

    // Events 5 down to 1 each set their own bit; a written zero keeps it, a written one clears it
    task automatic t_events();
        for (int k = 5; k >= 1; k--) begin
            pulse(k, 1);
            pin_chk("int_n set", 1'b0);
            rd_ok("event flag", ra(1, `LCIS_OFF_LINE), 32'(1 << k));
            wr_chk(ra(1, `LCIS_OFF_LINE), 32'h0, `LCIS_RESP_OKAY);
            rd_ok("flag after zero", ra(1, `LCIS_OFF_LINE), 32'(1 << k));
            wr_chk(ra(1, `LCIS_OFF_LINE), 32'(1 << k), `LCIS_RESP_OKAY);
            rd_ok("flag after one", ra(1, `LCIS_OFF_LINE), 32'h0);
            pin_chk("int_n clear", 1'b1);
        end
    endtask

    // Channel placement at both ends of the map, cross-channel pin and unmapped groups
    task automatic t_map();
        int chs [3] = '{0, 8, 2};
        foreach (chs[i]) begin
            pulse(5, chs[i]);
            rd_ok("own channel", ra(chs[i], `LCIS_OFF_LINE), 32'h20);
            rd_ok("other channel", ra(1, `LCIS_OFF_LINE), 32'h0);
            wr_chk(ra(chs[i], `LCIS_OFF_LINE), 32'h20, `LCIS_RESP_OKAY);
        end
        pulse(2, 0);
        pulse(4, 8);
        wr_chk(ra(0, `LCIS_OFF_LINE), 32'h04, `LCIS_RESP_OKAY);
        rd_ok("channel 0 cleared", ra(0, `LCIS_OFF_LINE), 32'h0);
        pin_chk("int_n other set", 1'b0);
        // A write with its low byte lane masked must leave the flag alone
        @(posedge aclk);
        s_axi_wstrb <= 4'h0;
        wr_chk(ra(8, `LCIS_OFF_LINE), 32'h10, `LCIS_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd_ok("channel 8 flag", ra(8, `LCIS_OFF_LINE), 32'h10);
        wr_chk(ra(8, `LCIS_OFF_LINE), 32'h10, `LCIS_RESP_OKAY);
        pin_chk("int_n all clear", 1'b1);
        rd_chk("unmapped group", 13'h0888, 32'h0, `LCIS_RESP_SLVERR);
        rd_chk("misaligned", 13'h0089, 32'h0, `LCIS_RESP_SLVERR);
        wr_chk(13'h1F00, 32'hFF, `LCIS_RESP_SLVERR);
    endtask

    task automatic t_loop();
        act(1'b1);
        rd_ok("state", ra(1, `LCIS_OFF_STATE), 32'h2);
        rd_ok("rise edge 0", ra(1, `LCIS_OFF_LOOP), 32'h2);
        wr_chk(ra(1, `LCIS_OFF_LOOP), 32'h2, `LCIS_RESP_OKAY);
        act(1'b0);
        rd_ok("fall edge 0", ra(1, `LCIS_OFF_LOOP), 32'h0);
        wr_chk(ra(1, `LCIS_OFF_EDGE), 32'h1, `LCIS_RESP_OKAY);
        rd_ok("edge select", ra(1, `LCIS_OFF_EDGE), 32'h1);
        act(1'b1);
        rd_ok("rise edge 1", ra(1, `LCIS_OFF_LOOP), 32'h2);
        wr_chk(ra(1, `LCIS_OFF_LOOP), 32'h2, `LCIS_RESP_OKAY);
        act(1'b0);
        rd_ok("fall edge 1", ra(1, `LCIS_OFF_LOOP), 32'h2);
        wr_chk(ra(1, `LCIS_OFF_LOOP), 32'h2, `LCIS_RESP_OKAY);
        pulse(6, 1);
        pin_chk("int_n deact", 1'b0);
        rd_ok("deact flag", ra(1, `LCIS_OFF_LOOP), 32'h1);
        wr_chk(ra(1, `LCIS_OFF_LOOP), 32'h1, `LCIS_RESP_OKAY);
        rd_ok("deact cleared", ra(1, `LCIS_OFF_LOOP), 32'h0);
        wr_chk(ra(1, `LCIS_OFF_EDGE), 32'h0, `LCIS_RESP_OKAY);
    endtask

    // Full 16-bit count: 65535 events stay below overflow, one more wraps and raises the flag
    task automatic t_count();
        @(posedge aclk);
        ev[0][1] <= 1'b1;
        repeat (65535) @(posedge aclk);
        ev[0][1] <= 1'b0;
        repeat (2) @(posedge aclk);
        rd_ok("count low full", ra(1, `LCIS_OFF_ERRL), 32'hFF);
        rd_ok("count high full", ra(1, `LCIS_OFF_ERRH), 32'hFF);
        rd_ok("no overflow yet", ra(1, `LCIS_OFF_LINE), 32'h0);
        pulse(0, 1);
        rd_ok("overflow flag", ra(1, `LCIS_OFF_LINE), 32'h1);
        rd_ok("count low wrap", ra(1, `LCIS_OFF_ERRL), 32'h0);
        rd_ok("count high wrap", ra(1, `LCIS_OFF_ERRH), 32'h0);
        pin_chk("int_n overflow", 1'b0);
        wr_chk(ra(1, `LCIS_OFF_LINE), 32'h1, `LCIS_RESP_OKAY);
        pin_chk("int_n final", 1'b1);
    endtask

    // Reset for five cycles, then every scenario in turn
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_events();
        t_map();
        t_loop();
        t_count();
        stop_test();
    end
endmodule // testbench
